// ---- rtl/fpm_pkg.sv ----
// Constants, types and register map of the flash partition map.
// Assumes a single 50 MHz clock and a synchronous active-low reset.
//
// Overview of operation
// - 24-bit word read as even/odd half-words.
// - 23-bit program counter, bit zero always zero.
// - sequential fetch adds two to counter.
// - table address is page over 16-bit word.
// - paged view is page over 15 bits.
// - mode field 11 single, 10/01/00 dual variants.
// - boot mode word never rewritten at run time.
// - single mode maps one range from zero.
// - dual mode halves at zero and 400000h.
// - dual boundaries are half of single ones.
// - initialisation maps partitions by sequence signature.
// - fetch only from active; inactive readable, writable.
// - inactive-region writes never stall the core.
// - software swap of partitions without reset.
// - plain dual mode adds no restriction.
// - protected mode blocks inactive partition 1 writes.
// - protected plus write-protect blocks partition 1 always.
// - privileged mode locks boot segment limit bits.
// - vector area ends 000100h or 000200h.
// - lower valid sequence wins, else partition 1.
// - sequence valid when upper field complements lower.
// - status bit shows partition 2 active.
`default_nettype none

package fpm_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TABLE_PAGE = 8'h08;
	localparam logic [7:0] REG_VIEW_PAGE = 8'h0C;
	localparam logic [7:0] REG_PC = 8'h10;
	localparam int CTRL_SWAP_BIT = 0;
	localparam int ST_P2_ACTIVE_BIT = 0;
	localparam int ST_MODE_LSB = 1;
	localparam int ST_SOFT_SWAP_BIT = 3;
	localparam int ST_BLOCKED_BIT = 4;
	localparam int ST_CFG_REJECT_BIT = 5;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [22:0] PC_RESET = 23'h000000;
	// ------------------------------------------------------------
	// address map
	// ------------------------------------------------------------
	localparam logic [23:0] INACTIVE_BASE = 24'h400000;
	localparam logic [23:0] CONFIG_BASE = 24'h800000;
	localparam logic [23:0] VECTOR_END_CORE = 24'h000100;
	localparam logic [23:0] VECTOR_END_DSP = 24'h000200;
	localparam logic [23:0] FLASH_TOP_DEFAULT = 24'h02B000;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PRIVILEGED,
		MODE_PROTECTED,
		MODE_DUAL,
		MODE_SINGLE
	} fpm_mode_e;
	typedef enum logic [1:0] {
		RG_ACTIVE,
		RG_INACTIVE,
		RG_CONFIG,
		RG_UNIMPL
	} fpm_region_e;
	typedef enum logic [1:0] {
		CFG_BOOT_MODE_WORD,
		CFG_BOOT_SEG_LIMIT,
		CFG_OTHER
	} fpm_cfg_target_e;
	typedef struct packed {
		logic valid;
		logic erase;
		logic [23:0] addr;
	} fpm_nvm_req_s;
	typedef struct packed {
		logic fault;
		logic phys_p2;
		logic config_space;
		logic [22:0] offset;
	} fpm_map_s;
endpackage : fpm_pkg

`default_nettype wire

// ---- rtl/fpm_top.sv ----
// Flash partition map: address formation, partition mapping and protection.
// Assumes an AHB-Lite master with this as its only slave, synchronous inputs.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`default_nettype none

module fpm_top #(
	parameter logic [23:0] FLASH_TOP = fpm_pkg::FLASH_TOP_DEFAULT,
	parameter bit DSP_VARIANT = 1'b1
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	// configuration words, stable from reset
	input wire logic [1:0] partition_mode_field_in,
	input wire logic [23:0] p1_sequence_word_in,
	input wire logic [23:0] p2_sequence_word_in,
	input wire logic p1_write_protect_in,
	// core fetch
	input wire logic pc_advance_in,
	input wire logic pc_load_in,
	input wire logic [22:0] pc_target_in,
	// table and paged view accesses
	input wire logic table_req_in,
	input wire logic [15:0] table_w_in,
	input wire logic [23:0] flash_word_in,
	input wire logic view_req_in,
	input wire logic [15:0] view_w_in,
	// flash programming controller
	input wire fpm_pkg::fpm_nvm_req_s nvm_req_in,
	input wire logic nvm_busy_in,
	input wire logic cfg_wr_in,
	input wire fpm_pkg::fpm_cfg_target_e cfg_target_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// results
	output logic [22:0] pc_out,
	output fpm_pkg::fpm_map_s fetch_map_out,
	output logic [23:0] table_ea_out,
	output fpm_pkg::fpm_map_s table_map_out,
	output logic [15:0] table_rdata_out,
	output logic [22:0] view_ea_out,
	output logic nvm_grant_out,
	output logic nvm_block_out,
	output logic nvm_phys_p2_out,
	output logic cpu_stall_out,
	output logic cfg_ack_out,
	output logic cfg_reject_out,
	output logic [23:0] vector_end_out,
	output logic second_partition_active_flag_out,
	output fpm_pkg::fpm_mode_e mode_out,
	output logic init_done_out
);
	// ------------------------------------------------------------
	// initialisation state
	// ------------------------------------------------------------
	typedef enum logic {
		ST_INIT,
		ST_RUN
	} fpm_state_e;

	fpm_state_e state;
	fpm_pkg::fpm_mode_e mode;
	logic p2_active;
	logic soft_swapped;
	logic [7:0] table_page_reg;
	logic [7:0] program_view_page_reg;
	logic blocked_sticky;
	logic cfg_reject_sticky;
	logic dual;
	logic [23:0] part_top;
	logic p1_seq_valid;
	logic p2_seq_valid;
	logic boot_p2;
	logic [22:0] next_pc;
	logic [23:0] next_table_ea;
	fpm_pkg::fpm_map_s next_fetch_map;
	fpm_pkg::fpm_map_s next_table_map;
	fpm_pkg::fpm_map_s nvm_map;
	logic nvm_blocked;
	logic swap_req;
	logic blocked_set;
	logic cfg_reject_set;
	logic ahb_wr_pend;
	logic ahb_rd_pend;
	logic [7:0] ahb_addr;
	logic ahb_accept;
	logic [31:0] rd_value;

	assign dual = (mode != fpm_pkg::MODE_SINGLE);
	assign part_top = dual ? (FLASH_TOP >> 1) : FLASH_TOP;

	// region decode shared by fetch, table and programming paths
	function automatic fpm_pkg::fpm_map_s map_addr(input logic [23:0] addr, input logic is_dual,
			input logic [23:0] top, input logic act_p2);
		fpm_pkg::fpm_map_s m;
		m = '0;
		m.offset = addr[22:0];
		if (addr >= fpm_pkg::CONFIG_BASE) begin
			m.config_space = 1'b1;
		end else if (!is_dual) begin
			m.fault = (addr >= top);
			m.phys_p2 = 1'b0;
		end else if (addr < fpm_pkg::INACTIVE_BASE) begin
			m.fault = (addr >= top);
			m.phys_p2 = act_p2;
		end else begin
			m.fault = ((addr - fpm_pkg::INACTIVE_BASE) >= top);
			m.phys_p2 = ~act_p2;
			m.offset = {1'b0, addr[21:0]};
		end
		return m;
	endfunction : map_addr

	assign p1_seq_valid = (p1_sequence_word_in[23:12] == ~p1_sequence_word_in[11:0]);
	assign p2_seq_valid = (p2_sequence_word_in[23:12] == ~p2_sequence_word_in[11:0]);
	assign boot_p2 = p2_seq_valid && (!p1_seq_valid || (p2_sequence_word_in[11:0] < p1_sequence_word_in[11:0]));

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			state <= ST_INIT;
		end else begin
			case (state)
				ST_INIT: state <= ST_RUN;
				ST_RUN: state <= ST_RUN;
				default: state <= ST_INIT;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			mode <= fpm_pkg::MODE_SINGLE;
		end else if (state == ST_INIT) begin
			mode <= fpm_pkg::fpm_mode_e'(partition_mode_field_in);
		end
	end

	// ------------------------------------------------------------
	// active partition selection
	// ------------------------------------------------------------
	assign swap_req = ahb_wr_pend && (ahb_addr == fpm_pkg::REG_CTRL) && hwdata_in[fpm_pkg::CTRL_SWAP_BIT];

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			p2_active <= 1'b0;
			soft_swapped <= 1'b0;
		end else if (state == ST_INIT) begin
			p2_active <= (partition_mode_field_in != 2'b11) && boot_p2;
			soft_swapped <= 1'b0;
		end else if (swap_req && dual) begin
			// run-time swap, single mode ignores it
			p2_active <= ~p2_active;
			soft_swapped <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// program counter and fetch
	// ------------------------------------------------------------
	always_comb begin
		next_pc = pc_out;
		if (pc_load_in) begin
			next_pc = {pc_target_in[22:1], 1'b0};
		end else if (pc_advance_in) begin
			next_pc = {pc_out[22:1] + 22'h000001, 1'b0};
		end
	end

	always_comb begin
		next_fetch_map = map_addr({1'b0, next_pc}, dual, part_top, p2_active);
		if (dual && next_pc[22]) begin
			next_fetch_map.fault = 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			pc_out <= fpm_pkg::PC_RESET;
			fetch_map_out <= '0;
		end else if (state == ST_RUN) begin
			pc_out <= next_pc;
			fetch_map_out <= next_fetch_map;
		end
	end

	// ------------------------------------------------------------
	// table and paged view addressing
	// ------------------------------------------------------------
	// page over working register
	assign next_table_ea = {table_page_reg, table_w_in};
	assign next_table_map = map_addr(next_table_ea, dual, part_top, p2_active);

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			table_ea_out <= '0;
			table_map_out <= '0;
			table_rdata_out <= '0;
			view_ea_out <= '0;
		end else begin
			if (table_req_in) begin
				table_ea_out <= next_table_ea;
				table_map_out <= next_table_map;
			end
			// odd address gives upper byte, top byte zero
			table_rdata_out <= table_ea_out[0] ? {8'h00, flash_word_in[23:16]} : flash_word_in[15:0];
			if (view_req_in) begin
				view_ea_out <= {program_view_page_reg, view_w_in[14:0]};
			end
		end
	end

	// ------------------------------------------------------------
	// write and erase protection
	// ------------------------------------------------------------
	assign nvm_map = map_addr(nvm_req_in.addr, dual, part_top, p2_active);

	always_comb begin
		nvm_blocked = nvm_map.fault || nvm_map.config_space;
		// plain dual mode adds nothing here
		if (mode == fpm_pkg::MODE_PROTECTED && !nvm_map.phys_p2 && !nvm_map.config_space) begin
			if (nvm_req_in.addr >= fpm_pkg::INACTIVE_BASE) begin
				nvm_blocked = 1'b1;
			end
			// write-protected partition 1 in any region
			if (p1_write_protect_in) begin
				nvm_blocked = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			nvm_grant_out <= 1'b0;
			nvm_block_out <= 1'b0;
			nvm_phys_p2_out <= 1'b0;
		end else begin
			// blocked request never granted to the array
			nvm_grant_out <= nvm_req_in.valid && !nvm_blocked && (state == ST_RUN);
			nvm_block_out <= nvm_req_in.valid && nvm_blocked;
			if (nvm_req_in.valid) begin
				nvm_phys_p2_out <= nvm_map.phys_p2;
			end
		end
	end

	// only a busy controller in single mode holds the core; dual mode never stalls
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			cpu_stall_out <= 1'b0;
		end else begin
			cpu_stall_out <= nvm_busy_in && !dual;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			cfg_ack_out <= 1'b0;
			cfg_reject_out <= 1'b0;
		end else begin
			cfg_ack_out <= cfg_wr_in && !cfg_reject_set;
			cfg_reject_out <= cfg_reject_set;
		end
	end

	always_comb begin
		cfg_reject_set = 1'b0;
		if (cfg_wr_in) begin
			// boot mode word fixed at run time
			if (cfg_target_in == fpm_pkg::CFG_BOOT_MODE_WORD) begin
				cfg_reject_set = 1'b1;
			end
			if (cfg_target_in == fpm_pkg::CFG_BOOT_SEG_LIMIT && mode == fpm_pkg::MODE_PRIVILEGED) begin
				cfg_reject_set = 1'b1;
			end
		end
	end

	assign blocked_set = nvm_req_in.valid && nvm_blocked;

	// sticky flags: a new event beats a same-cycle clear
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			blocked_sticky <= 1'b0;
			cfg_reject_sticky <= 1'b0;
		end else begin
			if (blocked_set) begin
				blocked_sticky <= 1'b1;
			end else if (ahb_wr_pend && ahb_addr == fpm_pkg::REG_STATUS && hwdata_in[fpm_pkg::ST_BLOCKED_BIT]) begin
				blocked_sticky <= 1'b0;
			end
			if (cfg_reject_set) begin
				cfg_reject_sticky <= 1'b1;
			end else if (ahb_wr_pend && ahb_addr == fpm_pkg::REG_STATUS
					&& hwdata_in[fpm_pkg::ST_CFG_REJECT_BIT]) begin
				cfg_reject_sticky <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			vector_end_out <= '0;
			second_partition_active_flag_out <= 1'b0;
			mode_out <= fpm_pkg::MODE_SINGLE;
			init_done_out <= 1'b0;
		end else begin
			vector_end_out <= DSP_VARIANT ? fpm_pkg::VECTOR_END_DSP : fpm_pkg::VECTOR_END_CORE;
			second_partition_active_flag_out <= p2_active;
			mode_out <= mode;
			init_done_out <= (state == ST_RUN);
		end
	end

	// ------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------
	// reads take one wait state so that hrdata comes from a flop
	assign ahb_accept = hsel_in && htrans_in[1] && hready_in;

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			ahb_wr_pend <= 1'b0;
			ahb_rd_pend <= 1'b0;
			ahb_addr <= '0;
		end else begin
			ahb_wr_pend <= ahb_accept && hwrite_in;
			ahb_rd_pend <= ahb_accept && !hwrite_in;
			if (ahb_accept) begin
				ahb_addr <= {haddr_in[7:2], 2'b00};
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			table_page_reg <= fpm_pkg::PAGE_RESET;
			program_view_page_reg <= fpm_pkg::PAGE_RESET;
		end else if (ahb_wr_pend) begin
			if (ahb_addr == fpm_pkg::REG_TABLE_PAGE) begin
				table_page_reg <= hwdata_in[7:0];
			end
			if (ahb_addr == fpm_pkg::REG_VIEW_PAGE) begin
				program_view_page_reg <= hwdata_in[7:0];
			end
		end
	end

	always_comb begin
		rd_value = 32'h00000000;
		case (ahb_addr)
			fpm_pkg::REG_STATUS: begin
				rd_value[fpm_pkg::ST_P2_ACTIVE_BIT] = p2_active;
				rd_value[fpm_pkg::ST_MODE_LSB +: 2] = mode;
				rd_value[fpm_pkg::ST_SOFT_SWAP_BIT] = soft_swapped;
				rd_value[fpm_pkg::ST_BLOCKED_BIT] = blocked_sticky;
				rd_value[fpm_pkg::ST_CFG_REJECT_BIT] = cfg_reject_sticky;
			end
			fpm_pkg::REG_TABLE_PAGE: rd_value[7:0] = table_page_reg;
			fpm_pkg::REG_VIEW_PAGE: rd_value[7:0] = program_view_page_reg;
			fpm_pkg::REG_PC: rd_value[22:0] = pc_out;
			default: rd_value = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			hrdata_out <= 32'h00000000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			hresp_out <= 1'b0;
			if (ahb_accept && !hwrite_in) begin
				hreadyout_out <= 1'b0;
			end else begin
				hreadyout_out <= 1'b1;
			end
			if (ahb_rd_pend) begin
				hrdata_out <= rd_value;
			end
		end
	end

	logic unused_ok;
	assign unused_ok = ^{hsize_in, haddr_in[31:8], haddr_in[1:0], nvm_req_in.erase, hwdata_in[31:8]};
endmodule : fpm_top

`default_nettype wire

// ---- verif/fpm_top_asserts.sv ----
// Concurrent checks of the flash partition map, seen at the ports of fpm_top.
// Assumes one clock domain and the synchronous active-low reset of the design.
`default_nettype none

module fpm_top_asserts #(
	parameter bit DSP_VARIANT = 1'b1
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [1:0] partition_mode_field_in,
	input wire logic p1_write_protect_in,
	input wire logic pc_advance_in,
	input wire logic pc_load_in,
	input wire logic [22:0] pc_target_in,
	input wire logic table_req_in,
	input wire logic [15:0] table_w_in,
	input wire logic [23:0] flash_word_in,
	input wire logic view_req_in,
	input wire logic [15:0] view_w_in,
	input wire fpm_pkg::fpm_nvm_req_s nvm_req_in,
	input wire logic cfg_wr_in,
	input wire fpm_pkg::fpm_cfg_target_e cfg_target_in,
	input wire logic [22:0] pc_out,
	input wire fpm_pkg::fpm_map_s fetch_map_out,
	input wire logic [23:0] table_ea_out,
	input wire logic [15:0] table_rdata_out,
	input wire logic [22:0] view_ea_out,
	input wire logic nvm_grant_out,
	input wire logic nvm_block_out,
	input wire logic cpu_stall_out,
	input wire logic cfg_ack_out,
	input wire logic cfg_reject_out,
	input wire logic [23:0] vector_end_out,
	input wire logic second_partition_active_flag_out,
	input wire fpm_pkg::fpm_mode_e mode_out,
	input wire logic init_done_out
);
	logic run;
	logic [23:0] ea_q;
	logic [23:0] word_q;
	assign run = init_done_out;
	// address and array word both sampled one cycle late, as the read data is
	always_ff @(posedge clock_in) begin
		ea_q <= table_ea_out;
		word_q <= flash_word_in;
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_pc_aligned: assert property (pc_out[0] == 1'b0)
		else $error("program counter lsb set");
	a_pc_step: assert property (run && pc_advance_in && !pc_load_in |=> pc_out == $past(pc_out) + 23'h000002)
		else $error("sequential step is not two");
	a_pc_load: assert property (run && pc_load_in |=> pc_out == ($past(pc_target_in) & 23'h7FFFFE))
		else $error("loaded counter wrong");
	a_fetch_upper: assert property (run && mode_out != fpm_pkg::MODE_SINGLE && pc_out[22] |-> fetch_map_out.fault)
		else $error("fetch from inactive region allowed");
	a_table_low: assert property (run && table_req_in |=> table_ea_out[15:0] == $past(table_w_in))
		else $error("table address low word wrong");
	a_table_half: assert property (run && table_req_in ##1 1'b1 |=>
		table_rdata_out == (ea_q[0] ? {8'h00, word_q[23:16]} : word_q[15:0]))
		else $error("table half-word wrong");
	a_view_low: assert property (run && view_req_in |=> {1'b0, view_ea_out[14:0]} == ($past(view_w_in) & 16'h7FFF))
		else $error("view address low bits wrong");
	a_mode_decode: assert property (run |-> mode_out == fpm_pkg::fpm_mode_e'(partition_mode_field_in))
		else $error("mode decode wrong");
	a_mode_hold: assert property (run |=> $stable(mode_out))
		else $error("mode changed while running");
	a_cfg_lock: assert property (run && cfg_wr_in && cfg_target_in == fpm_pkg::CFG_BOOT_MODE_WORD
		|=> cfg_reject_out && !cfg_ack_out)
		else $error("boot mode word accepted");
	a_seg_lock: assert property (run && cfg_wr_in && cfg_target_in == fpm_pkg::CFG_BOOT_SEG_LIMIT
		|=> cfg_reject_out == (mode_out == fpm_pkg::MODE_PRIVILEGED))
		else $error("segment limit lock wrong");
	a_p1_locked: assert property (run && nvm_req_in.valid && mode_out == fpm_pkg::MODE_PROTECTED && p1_write_protect_in
		&& !nvm_req_in.addr[23] && nvm_req_in.addr[22] == second_partition_active_flag_out
		|=> nvm_block_out && !nvm_grant_out)
		else $error("protected partition one written");
	a_nvm_answer: assert property (run && nvm_req_in.valid |=> nvm_grant_out != nvm_block_out)
		else $error("request not answered once");
	a_no_stall: assert property (run && mode_out != fpm_pkg::MODE_SINGLE |=> !cpu_stall_out)
		else $error("core stalled in dual mode");
	a_vector_end: assert property (run |-> vector_end_out == (DSP_VARIANT ? 24'h000200 : 24'h000100))
		else $error("vector area end wrong");
endmodule : fpm_top_asserts

bind fpm_top fpm_top_asserts #(.DSP_VARIANT(DSP_VARIANT)) i_fpm_top_asserts (.clock_in, .rstn_in,
	.partition_mode_field_in, .p1_write_protect_in, .pc_advance_in, .pc_load_in, .pc_target_in, .table_req_in,
	.table_w_in, .flash_word_in, .view_req_in, .view_w_in, .nvm_req_in, .cfg_wr_in, .cfg_target_in, .pc_out,
	.fetch_map_out, .table_ea_out, .table_rdata_out, .view_ea_out, .nvm_grant_out, .nvm_block_out, .cpu_stall_out,
	.cfg_ack_out, .cfg_reject_out, .vector_end_out, .second_partition_active_flag_out, .mode_out, .init_done_out);

`default_nettype wire

// ---- verif/fpm_flash_model.sv ----
// Far side of the map: flash array read port and programming controller busy.
// Assumes the table address of fpm_top addresses the array directly.
`default_nettype none

module fpm_flash_model #(
	parameter int BUSY_CYCLES = 4
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic [23:0] table_ea_in,
	input wire logic grant_in,
	output logic [23:0] flash_word_out,
	output logic busy_out
);
	int unsigned busy_left;
	// address-derived pattern so neighbouring words never read alike
	assign flash_word_out = {table_ea_in[7:0] ^ 8'h5A, table_ea_in[15:0]};
	assign busy_out = (busy_left != 0);
	always_ff @(posedge clock_in) begin
		if (!rstn_in) begin
			busy_left <= 0;
		end else if (grant_in) begin
			busy_left <= BUSY_CYCLES;
		end else if (busy_left != 0) begin
			busy_left <= busy_left - 1;
		end
	end
endmodule : fpm_flash_model

`default_nettype wire

// ---- verif/test_fpm_top.sv ----
// Self-checking bench for fpm_top: AHB-Lite register tasks and side-port pulses.
// Assumes fpm_flash_model on the far side and the checker bound to fpm_top.
`default_nettype none

module test_fpm_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0] m;
		logic [23:0] s1;
		logic [23:0] s2;
		logic [23:0] a;
		logic wp;
		logic blk;
		logic fl;
	} fpm_row_s;
	// mode, sequence words, nvm target, write protect, blocked, partition 2 active
	localparam fpm_row_s ROWS [5] = '{
		'{2'b11, 24'hFFA005, 24'hFFC003, 24'h02B000, 1'b1, 1'b1, 1'b0},
		'{2'b10, 24'hFFA005, 24'hFFC003, 24'h400010, 1'b1, 1'b0, 1'b1},
		'{2'b01, 24'h000005, 24'hFFC003, 24'h400010, 1'b0, 1'b1, 1'b1},
		'{2'b01, 24'hFFD002, 24'hFF6009, 24'h000010, 1'b1, 1'b1, 1'b0},
		'{2'b00, 24'h000005, 24'h000009, 24'h400010, 1'b1, 1'b0, 1'b0}
	};
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [1:0] partition_mode_field_in = 2'b11;
	logic [23:0] p1_sequence_word_in = 24'h000000;
	logic [23:0] p2_sequence_word_in = 24'h000000;
	logic p1_write_protect_in = 1'b0;
	logic pc_advance_in = 1'b0;
	logic pc_load_in = 1'b0;
	logic [22:0] pc_target_in = 23'h000000;
	logic table_req_in = 1'b0;
	logic [15:0] table_w_in = 16'h0000;
	logic [23:0] flash_word_in;
	logic view_req_in = 1'b0;
	logic [15:0] view_w_in = 16'h0000;
	fpm_pkg::fpm_nvm_req_s nvm_req_in = '0;
	logic nvm_busy_in;
	logic cfg_wr_in = 1'b0;
	fpm_pkg::fpm_cfg_target_e cfg_target_in = fpm_pkg::CFG_OTHER;
	logic hsel_in = 1'b0;
	logic [31:0] haddr_in = 32'h00000000;
	logic [1:0] htrans_in = 2'b00;
	logic hwrite_in = 1'b0;
	logic [31:0] hwdata_in = 32'h00000000;
	logic [31:0] hrdata_out;
	logic hreadyout_out;
	logic [22:0] pc_out;
	fpm_pkg::fpm_map_s fetch_map_out;
	logic [23:0] table_ea_out;
	logic [15:0] table_rdata_out;
	logic [22:0] view_ea_out;
	logic nvm_grant_out;
	logic nvm_block_out;
	logic cpu_stall_out;
	logic cfg_ack_out;
	logic cfg_reject_out;
	logic [23:0] vector_end_out;
	logic second_partition_active_flag_out;
	fpm_pkg::fpm_mode_e mode_out;
	logic init_done_out;
	int err_count = 0;
	int tests_run = 0;
	int cycles = 0;

	fpm_top i_fpm_top (.clock_in, .rstn_in, .partition_mode_field_in, .p1_sequence_word_in, .p2_sequence_word_in,
		.p1_write_protect_in, .pc_advance_in, .pc_load_in, .pc_target_in, .table_req_in, .table_w_in, .flash_word_in,
		.view_req_in, .view_w_in, .nvm_req_in, .nvm_busy_in, .cfg_wr_in, .cfg_target_in, .hsel_in, .haddr_in,
		.htrans_in, .hwrite_in, .hsize_in(3'b010), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
		.hreadyout_out, .hresp_out(), .pc_out, .fetch_map_out, .table_ea_out, .table_map_out(), .table_rdata_out,
		.view_ea_out, .nvm_grant_out, .nvm_block_out, .nvm_phys_p2_out(), .cpu_stall_out, .cfg_ack_out,
		.cfg_reject_out, .vector_end_out, .second_partition_active_flag_out, .mode_out, .init_done_out);
	fpm_flash_model i_fpm_flash_model (.clock_in, .rstn_in, .table_ea_in(table_ea_out), .grant_in(nvm_grant_out),
		.flash_word_out(flash_word_in), .busy_out(nvm_busy_in));

	always #10 clock_in = ~clock_in;
	// a hung handshake must still reach the verdict
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic conclude;
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clock_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'b10;
		hwrite_in <= wr;
		haddr_in <= {24'h000000, a};
		@(posedge clock_in);
		while (hreadyout_out !== 1'b1) @(posedge clock_in);
		htrans_in <= 2'b00;
		hsel_in <= 1'b0;
		hwdata_in <= d;
		@(posedge clock_in);
		while (hreadyout_out !== 1'b1) @(posedge clock_in);
		q = hrdata_out;
	endtask : ahb
	task automatic restart(input fpm_row_s r);
		@(posedge clock_in);
		rstn_in <= 1'b0;
		partition_mode_field_in <= r.m;
		p1_sequence_word_in <= r.s1;
		p2_sequence_word_in <= r.s2;
		p1_write_protect_in <= r.wp;
		repeat (6) @(posedge clock_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
	endtask : restart
	task automatic load_pc(input logic [22:0] t);
		@(posedge clock_in);
		pc_load_in <= 1'b1;
		pc_target_in <= t;
		@(posedge clock_in);
		pc_load_in <= 1'b0;
		#1;
	endtask : load_pc
	task automatic cfg_try(input fpm_pkg::fpm_cfg_target_e t);
		@(posedge clock_in);
		cfg_wr_in <= 1'b1;
		cfg_target_in <= t;
		@(posedge clock_in);
		cfg_wr_in <= 1'b0;
		#1;
	endtask : cfg_try
	task automatic nvm_try(input logic [23:0] a, input logic e);
		@(posedge clock_in);
		nvm_req_in <= '{valid: 1'b1, erase: e, addr: a};
		@(posedge clock_in);
		nvm_req_in <= '0;
		#1;
	endtask : nvm_try
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		fpm_row_s r;
		logic [22:0] top;
		logic [31:0] rd;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			restart(r);
			check(init_done_out, 1'b1);
			check(mode_out, r.m);
			check(second_partition_active_flag_out, r.fl);
			check(vector_end_out, 24'h000200);
			cfg_try(fpm_pkg::CFG_BOOT_MODE_WORD);
			check(cfg_reject_out, 1'b1);
			cfg_try(fpm_pkg::CFG_BOOT_SEG_LIMIT);
			check(cfg_reject_out, r.m == 2'b00);
			cfg_try(fpm_pkg::CFG_OTHER);
			check(cfg_ack_out, 1'b1);
			nvm_try(r.a, r.wp);
			check(nvm_block_out, r.blk);
			check(nvm_grant_out, !r.blk);
			nvm_try(24'h000100, 1'b0);
			repeat (2) @(posedge clock_in);
			#1;
			check(cpu_stall_out, r.m == 2'b11);
			top = (r.m == 2'b11) ? 23'h02B000 : 23'h015800;
			load_pc(top - 23'h000002);
			check(fetch_map_out.fault, 1'b0);
			load_pc(top);
			check(fetch_map_out.fault, 1'b1);
			ahb(1'b0, fpm_pkg::REG_STATUS, 32'h00000000, rd);
			check(rd[5:0], {1'b1, r.blk, 1'b0, r.m, r.fl});
			ahb(1'b1, fpm_pkg::REG_CTRL, 32'h00000001, rd);
			ahb(1'b0, fpm_pkg::REG_STATUS, 32'h00000000, rd);
			check({rd[3], rd[0]}, {r.m != 2'b11, r.fl ^ (r.m != 2'b11)});
		end
		ahb(1'b1, fpm_pkg::REG_STATUS, 32'h00000030, rd);
		ahb(1'b0, fpm_pkg::REG_STATUS, 32'h00000000, rd);
		check(rd[5:4], 2'b00);
		load_pc(23'h400000);
		check(fetch_map_out.fault, 1'b1);
		ahb(1'b0, fpm_pkg::REG_TABLE_PAGE, 32'h00000000, rd);
		check(rd, 32'h00000000);
		ahb(1'b1, fpm_pkg::REG_TABLE_PAGE, 32'h00000012, rd);
		ahb(1'b1, fpm_pkg::REG_VIEW_PAGE, 32'h0000005A, rd);
		@(posedge clock_in);
		table_req_in <= 1'b1;
		table_w_in <= 16'h3457;
		view_req_in <= 1'b1;
		view_w_in <= 16'hFFFF;
		@(posedge clock_in);
		table_req_in <= 1'b0;
		view_req_in <= 1'b0;
		#1;
		check(table_ea_out, 24'h123457);
		check(view_ea_out, 23'h2D7FFF);
		@(posedge clock_in);
		#1;
		check(table_rdata_out, 16'h000D);
		load_pc(23'h001235);
		check(pc_out, 23'h001234);
		@(posedge clock_in);
		pc_advance_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		pc_advance_in <= 1'b0;
		ahb(1'b0, fpm_pkg::REG_PC, 32'h00000000, rd);
		check(rd, 32'h0000123A);
		ahb(1'b1, 8'h3C, 32'hFFFFFFFF, rd);
		ahb(1'b0, 8'h3C, 32'h00000000, rd);
		check(rd, 32'h00000000);
		conclude();
	end
endmodule : test_fpm_top

`default_nettype wire
